// ### core/acp_top.sv
// configuration registers of the converter digital back end, axi4-lite
//
// How it works
// [RL1] reduced_drive_enable lowers cmos output drive
// [RL2] input buffer needs both enables, serial mode
// [RL3] out_clk_buffer_enable powers clock buffer, resets 1
// [RL4] single-edge clocking: rising edges, double input
// [RL5] 20-bit frame_clock_pattern spans three registers
// [RL6] bypass picks frame pattern from resolution
// [RL7] real 1-wire needs resolution-specific patterns
// [RL8] complex 1-wire, half-wire needs all ones
// [RL9] averaging gives (a+b)/2
// [RL10] averaging needs mux 11, decimator, feature path; the router averages on mux_en, select 11 and avg_en alone
// [RL11] filter_input_select routes channels to converters
// [RL12] feature_path_select zero bypasses feature block
// [RL13] decimator_enable switches both filters
// [RL14] routing only while filter_input_mux_enable set
// [RL15] 3-bit ratio: bypass, 2 to 32
// [RL16] real output: low-pass, no complex mixing
// [RL17] mixer_phase_invert flips oscillator phase
// [RL18] real mode forces tuning words to zero
// [RL19] reserved bits written zero, ignored
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
module acp_top
    import acp_pkg::*;
#(
    parameter int SAMPLE_W = 14
) (
    input wire logic aclk, // 40 mhz clock
    input wire logic aresetn, // sync reset, active low
    input wire logic ce, // clock enable, freezes all state
    // axi4-lite write address
    input wire logic [ACP_ADDR_W-1:0] s_axi_awaddr, // byte address
    input wire logic [2:0] s_axi_awprot, // ignored
    input wire logic s_axi_awvalid, // address valid
    output logic s_axi_awready, // address taken
    // axi4-lite write data
    input wire logic [ACP_DATA_W-1:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // data valid
    output logic s_axi_wready, // data taken
    // axi4-lite write response
    output logic [1:0] s_axi_bresp, // okay or slverr
    output logic s_axi_bvalid, // response valid
    input wire logic s_axi_bready, // response taken
    // axi4-lite read address
    input wire logic [ACP_ADDR_W-1:0] s_axi_araddr, // byte address
    input wire logic [2:0] s_axi_arprot, // ignored
    input wire logic s_axi_arvalid, // address valid
    output logic s_axi_arready, // address taken
    // axi4-lite read data
    output logic [ACP_DATA_W-1:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // okay or slverr
    output logic s_axi_rvalid, // data valid
    input wire logic s_axi_rready, // data taken
    // neighbouring configuration, same clock
    input wire logic serial_mode, // serial cmos interface chosen
    input wire logic ser_clk_companion_en, // companion input enable
    input wire logic [1:0] out_resolution, // 14, 16 or 18 bit
    // sample path
    input wire logic [SAMPLE_W-1:0] smp_a, // channel a sample
    input wire logic [SAMPLE_W-1:0] smp_b, // channel b sample
    input wire logic smp_valid, // samples valid
    output logic [SAMPLE_W-1:0] dc_a, // to down_converter a
    output logic [SAMPLE_W-1:0] dc_b, // to down_converter b
    output logic dc_valid, // routed samples valid
    // control outputs
    output logic reduced_drive, // output buffers at low drive
    output logic ser_clk_in_buf_on, // serial_clock_input buffer on
    output logic out_clk_buf_on, // output_data_clock buffer on
    output logic single_edge_clk, // data on rising edges only
    output logic [PAT_W-1:0] frame_clock_pattern, // effective pattern
    output logic feature_path_on, // data through feature block
    output logic decimator_on, // both decimation filters on
    output logic [2:0] decim_ratio, // ratio code, zero if unused
    output logic decim_bypass, // no decimation
    output logic real_output, // real low-pass decimation
    output logic complex_mix_on, // complex mixing active
    output logic tuning_word_force_zero, // clears tuning words
    output logic mixer_phase_invert // oscillator phase inverted
);

    // register file
    logic [7:0] oic;
    logic [7:0] pat_lo;
    logic [7:0] pat_mid;
    logic [7:0] pat_hi;
    logic [7:0] rte;
    logic [7:0] dec;
    logic [7:0] next_oic;
    logic [7:0] next_pat_lo;
    logic [7:0] next_pat_mid;
    logic [7:0] next_pat_hi;
    logic [7:0] next_rte;
    logic [7:0] next_dec;

    // write channel state
    acp_wr_e wr_state;
    acp_wr_e next_wr_state;
    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic aw_ok;
    logic [7:0] w_byte;
    logic w_lane;
    logic next_aw_held;
    logic next_w_held;
    logic [5:0] next_aw_idx;
    logic next_aw_ok;
    logic [7:0] next_w_byte;
    logic next_w_lane;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic do_write;

    // read channel state
    acp_rd_e rd_state;
    acp_rd_e next_rd_state;
    logic next_arready;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [ACP_DATA_W-1:0] next_rdata;
    logic [7:0] rd_byte;
    logic rd_ok;

    // registered control outputs
    logic next_reduced_drive;
    logic next_ser_clk_in_buf_on;
    logic next_out_clk_buf_on;
    logic next_single_edge_clk;
    logic next_feature_path_on;
    logic next_decimator_on;
    logic [2:0] next_decim_ratio;
    logic next_decim_bypass;
    logic next_real_output;
    logic next_complex_mix_on;
    logic next_tuning_word_force_zero;
    logic next_mixer_phase_invert;

    // true when a word address lands on a mapped register
    function automatic logic idx_mapped(input logic [5:0] idx);
        case (idx)
            REG_OUT_IF_CTRL, REG_PAT_LOW, REG_PAT_MID, REG_PAT_HIGH,
            REG_ROUTE_CTRL, REG_DECIM_CTRL: idx_mapped = 1'b1;
            default: idx_mapped = 1'b0;
        endcase
    endfunction

    // unmapped slots and sub-word addresses read zero
    function automatic logic [7:0] reg_read(input logic [5:0] idx);
        case (idx)
            REG_OUT_IF_CTRL: reg_read = oic;
            REG_PAT_LOW: reg_read = pat_lo;
            REG_PAT_MID: reg_read = pat_mid;
            REG_PAT_HIGH: reg_read = pat_hi;
            REG_ROUTE_CTRL: reg_read = rte;
            REG_DECIM_CTRL: reg_read = dec;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // write path: address and data taken in either order, then answer
    always_comb begin
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_idx = aw_idx;
        next_aw_ok = aw_ok;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        do_write = 1'b0;
        case (wr_state)
            WR_IDLE: begin
                if (aw_held && w_held) begin
                    do_write = aw_ok && w_lane;
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_bvalid = 1'b1;
                    next_bresp = aw_ok ? RESP_OKAY : RESP_SLVERR;
                    next_wr_state = WR_RESP;
                end else begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        next_aw_held = 1'b1;
                        next_aw_idx = s_axi_awaddr[ACP_ADDR_W-1:2];
                        next_aw_ok = (s_axi_awaddr[1:0] == 2'h0) &&
                            idx_mapped(s_axi_awaddr[ACP_ADDR_W-1:2]);
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        next_w_held = 1'b1;
                        next_w_byte = s_axi_wdata[7:0];
                        next_w_lane = s_axi_wstrb[0];
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_wr_state = WR_IDLE;
                end
            end
            default: begin
                next_bvalid = 1'b0;
                next_wr_state = WR_IDLE;
            end
        endcase
        // one write at a time: each ready only while its own half of the write is not held
        next_awready = (next_wr_state == WR_IDLE) && !next_aw_held;
        next_wready = (next_wr_state == WR_IDLE) && !next_w_held;
    end

    // register updates; reserved bits are masked so they stay zero
    always_comb begin
        next_oic = oic;
        next_pat_lo = pat_lo;
        next_pat_mid = pat_mid;
        next_pat_hi = pat_hi;
        next_rte = rte;
        next_dec = dec;
        if (do_write) begin
            case (aw_idx)
                REG_OUT_IF_CTRL: next_oic = w_byte & OIC_WMASK; // RL19
                REG_PAT_LOW: next_pat_lo = w_byte & PAT_FULL_WMASK;
                REG_PAT_MID: next_pat_mid = w_byte & PAT_FULL_WMASK;
                REG_PAT_HIGH: next_pat_hi = w_byte & PAT_HIGH_WMASK;
                REG_ROUTE_CTRL: next_rte = w_byte & RTE_WMASK; // RL19
                REG_DECIM_CTRL: next_dec = w_byte & DEC_WMASK; // RL19
                default: next_dec = dec;
            endcase
        end
    end

    // read path: data registered one cycle after the address is taken
    always_comb begin
        next_rd_state = rd_state;
        next_arready = (rd_state == RD_IDLE);
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        rd_ok = (s_axi_araddr[1:0] == 2'h0) &&
            idx_mapped(s_axi_araddr[ACP_ADDR_W-1:2]);
        rd_byte = rd_ok ? reg_read(s_axi_araddr[ACP_ADDR_W-1:2]) : 8'h00;
        case (rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rdata = {24'h000000, rd_byte};
                    next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
                    next_rd_state = RD_DATA;
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_rd_state = RD_IDLE;
                end
            end
            default: begin
                next_rvalid = 1'b0;
                next_arready = 1'b1;
                next_rd_state = RD_IDLE;
            end
        endcase
    end

    // control decode from the register fields
    always_comb begin
        next_reduced_drive = oic[OIC_REDUCED_DRIVE]; // RL1
        next_ser_clk_in_buf_on = oic[OIC_SER_CLK_IN_EN] &&
            ser_clk_companion_en && serial_mode; // RL2
        next_out_clk_buf_on = oic[OIC_OUT_CLK_BUF_EN]; // RL3
        next_single_edge_clk = oic[OIC_SINGLE_EDGE] && serial_mode; // RL4
        next_feature_path_on = rte[RTE_FEATURE]; // RL12
        next_decimator_on = rte[RTE_DEC_EN]; // RL13
        // unused ratio codes fall back to bypass
        case (acp_ratio_e'(dec[DEC_RATIO_LSB +: 3])) // RL15
            RATIO_BYPASS, RATIO_DIV2, RATIO_DIV4, RATIO_DIV8,
            RATIO_DIV16, RATIO_DIV32:
                next_decim_ratio = dec[DEC_RATIO_LSB +: 3];
            default: next_decim_ratio = RATIO_BYPASS;
        endcase
        next_decim_bypass = (next_decim_ratio == RATIO_BYPASS);
        next_real_output = dec[DEC_REAL_OUT]; // RL16
        next_complex_mix_on = rte[RTE_DEC_EN] && !dec[DEC_REAL_OUT];
        next_tuning_word_force_zero = dec[DEC_REAL_OUT]; // RL18
        next_mixer_phase_invert = dec[DEC_MIX_PHASE]; // RL17
    end

    // all state, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oic <= OIC_RESET; // RL3
            pat_lo <= PAT_RESET;
            pat_mid <= PAT_RESET;
            pat_hi <= PAT_RESET;
            rte <= RTE_RESET;
            dec <= DEC_RESET;
            wr_state <= WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 6'h00;
            aw_ok <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            rd_state <= RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            reduced_drive <= 1'b0;
            ser_clk_in_buf_on <= 1'b0;
            out_clk_buf_on <= OIC_RESET[OIC_OUT_CLK_BUF_EN]; // RL3
            single_edge_clk <= 1'b0;
            feature_path_on <= 1'b0;
            decimator_on <= 1'b0;
            decim_ratio <= RATIO_BYPASS;
            decim_bypass <= 1'b1;
            real_output <= 1'b0;
            complex_mix_on <= 1'b0;
            tuning_word_force_zero <= 1'b0;
            mixer_phase_invert <= 1'b0;
        end else if (ce) begin
            oic <= next_oic;
            pat_lo <= next_pat_lo;
            pat_mid <= next_pat_mid;
            pat_hi <= next_pat_hi;
            rte <= next_rte;
            dec <= next_dec;
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_idx <= next_aw_idx;
            aw_ok <= next_aw_ok;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            rd_state <= next_rd_state;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            reduced_drive <= next_reduced_drive;
            ser_clk_in_buf_on <= next_ser_clk_in_buf_on;
            out_clk_buf_on <= next_out_clk_buf_on;
            single_edge_clk <= next_single_edge_clk;
            feature_path_on <= next_feature_path_on;
            decimator_on <= next_decimator_on;
            decim_ratio <= next_decim_ratio;
            decim_bypass <= next_decim_bypass;
            real_output <= next_real_output;
            complex_mix_on <= next_complex_mix_on;
            tuning_word_force_zero <= next_tuning_word_force_zero;
            mixer_phase_invert <= next_mixer_phase_invert;
        end
    end

    // routing mux and averaging in front of the down_converters
    acp_sample_router #(
        .SAMPLE_W(SAMPLE_W)
    ) u_router (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .smp_a(smp_a),
        .smp_b(smp_b),
        .smp_valid(smp_valid),
        .mux_en(dec[DEC_MUX_EN]), // RL14
        .sel(rte[RTE_SEL_LSB +: 2]), // RL11
        .avg_en(rte[RTE_CH_AVG]), // RL9
        .dc_a(dc_a),
        .dc_b(dc_b),
        .dc_valid(dc_valid)
    );

    // software must pick patterns for decimating modes itself
    acp_frame_pattern u_pattern (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .prog_pat({pat_hi[3:0], pat_mid, pat_lo}), // RL5
        .bypass(next_decim_bypass), // RL6
        .res(out_resolution),
        .pat(frame_clock_pattern)
    );

endmodule

// ### core/acp_pkg.sv
// constants, encodings and register map of the converter digital path config
package acp_pkg;

    // bus geometry
    localparam int ACP_ADDR_W = 8;
    localparam int ACP_DATA_W = 32;
    localparam int ACP_REG_W = 8;

    // register indices; byte address is four times the index
    localparam logic [5:0] REG_OUT_IF_CTRL = 6'h1F;
    localparam logic [5:0] REG_PAT_LOW = 6'h20;
    localparam logic [5:0] REG_PAT_MID = 6'h21;
    localparam logic [5:0] REG_PAT_HIGH = 6'h22;
    localparam logic [5:0] REG_ROUTE_CTRL = 6'h24;
    localparam logic [5:0] REG_DECIM_CTRL = 6'h25;

    // output_interface_control fields
    localparam int OIC_REDUCED_DRIVE = 7;
    localparam int OIC_SER_CLK_IN_EN = 6;
    localparam int OIC_OUT_CLK_BUF_EN = 4;
    localparam int OIC_SINGLE_EDGE = 3;
    localparam logic [7:0] OIC_WMASK = 8'hD8;
    localparam logic [7:0] OIC_RESET = 8'h10;

    // frame pattern fields
    localparam logic [7:0] PAT_FULL_WMASK = 8'hFF;
    localparam logic [7:0] PAT_HIGH_WMASK = 8'h0F;
    localparam logic [7:0] PAT_RESET = 8'h00;
    localparam int PAT_W = 20;

    // datapath_routing_control fields
    localparam int RTE_CH_AVG = 5;
    localparam int RTE_SEL_LSB = 3;
    localparam int RTE_FEATURE = 2;
    localparam int RTE_DEC_EN = 1;
    localparam logic [7:0] RTE_WMASK = 8'h3E;
    localparam logic [7:0] RTE_RESET = 8'h00;

    // decimation_control fields
    localparam int DEC_MUX_EN = 7;
    localparam int DEC_RATIO_LSB = 4;
    localparam int DEC_REAL_OUT = 3;
    localparam int DEC_MIX_PHASE = 0;
    localparam logic [7:0] DEC_WMASK = 8'hF9;
    localparam logic [7:0] DEC_RESET = 8'h00;

    // decimation ratio codes
    typedef enum logic [2:0] {
        RATIO_BYPASS = 3'h0,
        RATIO_DIV2 = 3'h1,
        RATIO_DIV4 = 3'h2,
        RATIO_DIV8 = 3'h3,
        RATIO_DIV16 = 3'h4,
        RATIO_DIV32 = 3'h5
    } acp_ratio_e;

    // filter input routing codes
    typedef enum logic [1:0] {
        ROUTE_DIRECT = 2'h0,
        ROUTE_CH_A = 2'h1,
        ROUTE_CH_B = 2'h2,
        ROUTE_AVERAGE = 2'h3
    } acp_route_e;

    // output resolution codes
    typedef enum logic [1:0] {
        RES_14 = 2'h0,
        RES_16 = 2'h1,
        RES_18 = 2'h2
    } acp_res_e;

    // frame patterns applied automatically in decimation bypass
    localparam logic [19:0] BYP_PAT_14 = 20'hFE000;
    localparam logic [19:0] BYP_PAT_16 = 20'hFF000;
    localparam logic [19:0] BYP_PAT_18 = 20'hFF800;

    // bus state machines, gray along the path
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } acp_wr_e;
    typedef enum logic {
        RD_IDLE = 1'h0,
        RD_DATA = 1'h1
    } acp_rd_e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### core/acp_sample_router.sv
// averaging block and routing mux in front of the two down_converters
`timescale 1ns/100ps
module acp_sample_router
    import acp_pkg::*;
#(
    parameter int SAMPLE_W = 14
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic ce, // clock enable
    input wire logic [SAMPLE_W-1:0] smp_a, // channel a sample, signed
    input wire logic [SAMPLE_W-1:0] smp_b, // channel b sample, signed
    input wire logic smp_valid, // samples valid
    input wire logic mux_en, // routing mux enabled
    input wire logic [1:0] sel, // filter_input_select
    input wire logic avg_en, // channel_average_enable
    output logic [SAMPLE_W-1:0] dc_a, // to down_converter a
    output logic [SAMPLE_W-1:0] dc_b, // to down_converter b
    output logic dc_valid // outputs valid
);

    if (SAMPLE_W < 2) begin : g_chk
        $error("acp_sample_router: SAMPLE_W too small");
    end

    logic [SAMPLE_W:0] sum;
    logic [SAMPLE_W-1:0] avg;
    logic [SAMPLE_W-1:0] next_dc_a;
    logic [SAMPLE_W-1:0] next_dc_b;
    logic next_dc_valid;

    // sign-extended sum keeps the carry so the halving never wraps
    always_comb begin
        sum = {smp_a[SAMPLE_W-1], smp_a} + {smp_b[SAMPLE_W-1], smp_b};
        avg = avg_en ? sum[SAMPLE_W:1] : '0; // RL9
        next_dc_a = smp_a;
        next_dc_b = smp_b;
        if (mux_en) begin // RL14
            case (acp_route_e'(sel)) // RL11
                ROUTE_DIRECT: begin
                    next_dc_a = smp_a;
                    next_dc_b = smp_b;
                end
                ROUTE_CH_A: begin
                    next_dc_a = smp_a;
                    next_dc_b = smp_a;
                end
                ROUTE_CH_B: begin
                    next_dc_a = smp_b;
                    next_dc_b = smp_b;
                end
                default: begin
                    next_dc_a = avg;
                    next_dc_b = avg;
                end
            endcase
        end
        next_dc_valid = smp_valid;
    end

    // output registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dc_a <= '0;
            dc_b <= '0;
            dc_valid <= 1'b0;
        end else if (ce) begin
            dc_a <= next_dc_a;
            dc_b <= next_dc_b;
            dc_valid <= next_dc_valid;
        end
    end

endmodule

// ### core/acp_frame_pattern.sv
// effective frame clock pattern: programmed, or automatic in bypass
`timescale 1ns/100ps
module acp_frame_pattern
    import acp_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic ce, // clock enable
    input wire logic [PAT_W-1:0] prog_pat, // programmed pattern
    input wire logic bypass, // decimation bypassed
    input wire logic [1:0] res, // output resolution code
    output logic [PAT_W-1:0] pat // pattern to the frame_clock
);

    logic [PAT_W-1:0] next_pat;

    // bypass ignores software's pattern and follows resolution
    always_comb begin
        next_pat = prog_pat; // RL5
        if (bypass) begin // RL6
            case (acp_res_e'(res))
                RES_14: next_pat = BYP_PAT_14;
                RES_16: next_pat = BYP_PAT_16;
                RES_18: next_pat = BYP_PAT_18;
                default: next_pat = BYP_PAT_14;
            endcase
        end
    end

    // pattern register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pat <= '0;
        end else if (ce) begin
            pat <= next_pat;
        end
    end

endmodule

// ### tb/acp_chk.sv
// assertions on the port behaviour of the config block
`timescale 1ns/100ps
module acp_chk
    import acp_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, // read
    input wire logic serial_mode, ser_clk_companion_en, // side inputs
    input wire logic [1:0] out_resolution, // resolution code
    input wire logic reduced_drive, ser_clk_in_buf_on, // controls
    input wire logic out_clk_buf_on, single_edge_clk, // controls
    input wire logic [PAT_W-1:0] frame_clock_pattern, // effective
    input wire logic decimator_on, decim_bypass, real_output, // controls
    input wire logic [2:0] decim_ratio, // ratio code
    input wire logic complex_mix_on, tuning_word_force_zero // controls
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // four quiet edges let the single-register pattern pipe settle
    sequence s_byp_steady;
        (decim_bypass && $stable(out_resolution))[*4];
    endsequence
    chk_byp_pattern: assert property (s_byp_steady |->
        frame_clock_pattern == (out_resolution == 2'h2 ? 20'hFF800 :
        out_resolution == 2'h1 ? 20'hFF000 : 20'hFE000))
        else $error("bypass pattern wrong");
    chk_ratio_flag: assert property (
        decim_bypass == (decim_ratio == 3'h0)) else $error("bypass flag");
    chk_ratio_codes: assert property (
        decim_ratio <= 3'h5) else $error("unused ratio code out");
    chk_real_zero: assert property (
        tuning_word_force_zero == real_output) else $error("nco force");
    chk_mix_off: assert property (
        complex_mix_on == (decimator_on && !real_output))
        else $error("complex mixing wrong");
    chk_clkin_gate: assert property (ser_clk_in_buf_on |->
        $past(serial_mode && ser_clk_companion_en)) else $error("clkin");
    chk_edge_gate: assert property (
        single_edge_clk |-> $past(serial_mode)) else $error("edge mode");
    chk_reset_vals: assert property ($rose(aresetn) |->
        out_clk_buf_on && decim_bypass && !reduced_drive)
        else $error("reset values wrong");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind acp_top acp_chk u_chk (.*);

// ### tb/adc_digital_path_config_tb.sv
// register and routing tests of the config block
`timescale 1ns/100ps
module adc_digital_path_config_tb;
    import acp_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, serial_mode = 1, smp_valid = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, decim_ratio;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ser_clk_companion_en = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, dc_valid, reduced_drive, ser_clk_in_buf_on;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, out_resolution = 0, rs;
    logic [13:0] smp_a = 14'h0064, smp_b = 14'h3FD8, dc_a, dc_b;
    logic [13:0] ea[4] = '{14'h0064, 14'h0064, 14'h3FD8, 14'h001E};
    logic [13:0] eb[4] = '{14'h3FD8, 14'h0064, 14'h3FD8, 14'h001E};
    logic out_clk_buf_on, single_edge_clk, feature_path_on, decimator_on;
    logic decim_bypass, real_output, complex_mix_on, mixer_phase_invert;
    logic tuning_word_force_zero;
    logic [19:0] frame_clock_pattern;
    int fails = 0, check_count = 0;
    acp_top dut (.*);
    always #12.5 aclk = ~aclk;
    task automatic end_sim;
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // write: address and data offered together, bready held up
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) begin
            fails++;
            end_sim();
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] p);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        p = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) begin
            fails++;
            end_sim();
        end
    endtask
    // main sequence; control outputs lag writes by up to two cycles
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(8'h7C, r, rs); chk(r, 32'h10);
        wr(8'h7C, 32'hFF);
        rd(8'h7C, r, rs); chk(r, 32'hD8);
        chk(reduced_drive, 1);
        chk(ser_clk_in_buf_on, 1);
        chk(single_edge_clk, 1);
        ser_clk_companion_en <= 1'b0;
        serial_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({ser_clk_in_buf_on, single_edge_clk}, 0);
        wr(8'h7C, 32'h0);
        repeat (3) @(posedge aclk);
        chk({out_clk_buf_on, reduced_drive}, 0);
        wr(8'h80, 32'h00);
        wr(8'h84, 32'hE0);
        wr(8'h88, 32'hFF);
        rd(8'h88, r, rs); chk(r, 32'h0F);
        wr(8'h94, 32'h18);
        repeat (3) @(posedge aclk);
        chk(frame_clock_pattern, 20'hFE000);
        wr(8'h94, 32'h0);
        out_resolution <= 2'h2;
        repeat (4) @(posedge aclk);
        chk(frame_clock_pattern, 20'hFF800);
        for (int i = 0; i < 8; i++) begin
            wr(8'h94, {25'h0, i[2:0], 4'h0});
            repeat (3) @(posedge aclk);
            chk(decim_ratio, (i <= 5) ? i : 0);
        end
        wr(8'h90, 32'h02);
        wr(8'h94, 32'h18);
        repeat (3) @(posedge aclk);
        chk({real_output, tuning_word_force_zero, complex_mix_on}, 6);
        wr(8'h80, 32'hFF); wr(8'h84, 32'hFF);
        wr(8'h94, 32'h11);
        repeat (3) @(posedge aclk);
        chk({complex_mix_on, mixer_phase_invert, decimator_on}, 7);
        chk(frame_clock_pattern, 20'hFFFFF);
        for (int m = 0; m < 2; m++) begin
            wr(8'h94, {24'h0, m[0], 7'h0});
            for (int s = 0; s < 4; s++) begin
                wr(8'h90, {26'h0, 1'b1, s[1:0], 3'h6});
                repeat (3) @(posedge aclk);
                chk(dc_a, m ? ea[s] : smp_a);
                chk(dc_b, m ? eb[s] : smp_b);
                chk({feature_path_on, dc_valid}, 3);
            end
        end
        rd(8'h00, r, rs); chk(rs, 2); chk(r, 0);
        end_sim();
    end
endmodule
